// ### pkg/spi_port_map.svh
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_BUF       8'h04
`define OFS_IRQ_ST    8'h08
`define OFS_IRQ_MASK  8'h0c
`define OFS_STATUS    8'h94

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CTRL_WRITE_COLLISION_FLAG     7
`define CTRL_OVF      6
`define CTRL_EN       5
`define CTRL_CKP      4
`define STAT_SMP      7
`define STAT_CKE      6
`define STAT_BF       0
`define IRQ_DONE      0
`define IRQ_WRITE_COLLISION_FLAG      1
`define IRQ_OVF       2
`define CTRL_RST      8'h00
`define STAT_RST      2'h0

// ----------------------------------------
// timing counts
// ----------------------------------------
`define HALF_DIV4     6'd2
`define HALF_DIV16    6'd8
`define HALF_DIV64    6'd32
`define LAST_EDGE     5'd16
`define MASTER_END    5'd17
`define FIRST_SHIFT   5'd2
`define LAST_SHIFT    5'd15

`endif

// ### pkg/spi_port_pkg.sv
package spi_port_pkg;

  // port_mode_select codes used by the serial engine
  typedef enum logic [3:0] {
    MODE_M4      = 4'b0000,
    MODE_M16     = 4'b0001,
    MODE_M64     = 4'b0010,
    MODE_MT2     = 4'b0011,
    MODE_S_SEL   = 4'b0100,
    MODE_S_NOSEL = 4'b0101
  } port_mode_t;

  typedef struct packed {
    logic       write_collision_flag;
    logic       ovf;
    logic       en;
    logic       clock_idle_polarity;
    logic [3:0] mode;
  } port_ctrl_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
  } pins_out_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_RUN  = 2'b01
  } eng_state_t;

endpackage : spi_port_pkg

// ### src/sync2.sv
`timescale 1ns/1ps

// two-flop synchroniser for pins from outside the clock domain
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // only the second stage is visible outside
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : sync2

// ### src/rate_div.sv
`timescale 1ns/1ps
`include "spi_port_map.svh"

// half-period enable for the master serial clock
module rate_div (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       clr,
  input  wire logic [1:0] sel,
  input  wire logic       ext_tick,
  output logic            tick
);

  logic [5:0] cnt_r;
  logic [5:0] half;

  // half period in core cycles per rate code
  always_comb begin
    case (sel)
      2'b00:   half = `HALF_DIV4;
      2'b01:   half = `HALF_DIV16;
      2'b10:   half = `HALF_DIV64;
      default: half = `HALF_DIV4;
    endcase
  end

  // clr restarts the counter phase so the first half period is full length, except on the timer code
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 6'h00;
    end else if (clr || cnt_r == half - 6'd1) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_r + 6'd1;
    end
  end

  // timer code: each timer match is one half period (output/2)
  assign tick = !clr && ((sel == 2'b11) ? ext_tick : (cnt_r == half - 6'd1));

endmodule : rate_div

// ### src/spi_serial_port.sv
`timescale 1ns/1ps
`include "spi_port_map.svh"

module spi_serial_port (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire logic                    sck_i,
  input  wire logic                    sdi_i,
  input  wire logic                    ss_n_i,
  input  wire logic                    tmr2_match,
  output spi_port_pkg::pins_out_t      pins,
  output logic                         irq
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  spi_port_pkg::port_ctrl_t  ctrl_r;
  spi_port_pkg::eng_state_t  state_r;
  logic        smp_r, cke_r, bf_r;
  logic [7:0]  buf_r, tx_r, rx_r, rx_in;
  logic [4:0]  h_r, h_nxt;
  logic        sck_lvl_r, sck_d_r;
  logic [2:0]  irq_st_r, irq_mask_r, irq_ev;
  logic        dp_wr_r;
  logic [7:0]  dp_addr_r;
  logic        sck_s, sdi_s, ss_n_s;
  logic        tick, ap_take, ap_rd, buf_rd, buf_we;
  logic        master, slave, sel_ok, ss_reset, busy;
  logic        step, last, samp, shft, done, write_collision_flag_set, ovf_set, start;
  logic        smp_eff;
  logic [7:0]  rd_val;

  // ----------------------------------------
  // pin synchronisers and clock divider
  // ----------------------------------------
  sync2 #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       ({sck_i, sdi_i, ss_n_i}),
    .q       ({sck_s, sdi_s, ss_n_s})
  );

  rate_div u_div (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clr      (!busy || !master),
    .sel      (ctrl_r.mode[1:0]),
    .ext_tick (tmr2_match),
    .tick     (tick)
  );

  // ----------------------------------------
  // mode decode and event terms
  // ----------------------------------------
  // codes above 0101 leave the engine idle
  assign master   = ctrl_r.en && (ctrl_r.mode[3:2] == 2'b00);
  assign slave    = ctrl_r.en && (ctrl_r.mode == spi_port_pkg::MODE_S_SEL ||
                                  ctrl_r.mode == spi_port_pkg::MODE_S_NOSEL);
  // master never looks at the select pin
  assign sel_ok   = (ctrl_r.mode == spi_port_pkg::MODE_S_NOSEL) || !ss_n_s;
  assign ss_reset = slave && (ctrl_r.mode == spi_port_pkg::MODE_S_SEL) && ss_n_s;
  assign busy     = (state_r == spi_port_pkg::ENG_RUN);
  // slave keeps input_sample_phase out of play
  assign smp_eff  = smp_r && master;
  assign ap_take  = hsel && htrans[1] && hready;
  assign ap_rd    = ap_take && !hwrite && (haddr[31:8] == 24'h0);
  assign buf_rd   = ap_rd && (haddr[7:0] == `OFS_BUF);
  assign buf_we   = dp_wr_r && (dp_addr_r == `OFS_BUF);

  // one step per master half period or per slave clock edge
  assign step  = master ? (busy && tick)
                        : (slave && sel_ok && !ss_reset && (sck_s != sck_d_r));
  assign h_nxt = h_r + 5'd1;
  assign last  = master ? (h_nxt == `MASTER_END) : (h_nxt == `LAST_EDGE);
  // sample on the edge opposite the output edge, or one half later
  assign samp  = step && (h_nxt[0] == !(cke_r ^ smp_eff)) && (h_nxt <= `LAST_EDGE + {4'h0, cke_r && smp_eff})
                 && !(cke_r && smp_eff && h_nxt == 5'd1);
  assign shft  = step && (h_nxt[0] == cke_r) &&
                 (h_nxt >= `FIRST_SHIFT) && (h_nxt <= `LAST_SHIFT);
  assign done  = step && last;
  assign rx_in = samp ? {rx_r[6:0], sdi_s} : rx_r;
  assign start    = buf_we && master && !busy;
  assign write_collision_flag_set = buf_we && busy;
  assign ovf_set  = done && slave && bf_r;
  assign irq_ev   = {ovf_set, write_collision_flag_set, done};

  // ----------------------------------------
  // bus slave: address phase capture
  // ----------------------------------------
  // zero wait state; reads are answered from the address phase
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_wr_r   <= ap_take && hwrite && (haddr[31:8] == 24'h0);
      dp_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    case (haddr[7:0])
      `OFS_CTRL:     rd_val = ctrl_r;
      `OFS_BUF:      rd_val = buf_r;
      `OFS_IRQ_ST:   rd_val = {5'h00, irq_st_r};
      `OFS_IRQ_MASK: rd_val = {5'h00, irq_mask_r};
      `OFS_STATUS:   rd_val = {smp_r, cke_r, 5'h00, bf_r};
      default:       rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_rd) begin
      hrdata <= {24'h00_0000, rd_val};
    end
  end

  // ----------------------------------------
  // control and status registers
  // ----------------------------------------
  // hardware set of a flag wins over a software write in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= `CTRL_RST;
    end else begin
      if (dp_wr_r && dp_addr_r == `OFS_CTRL) begin
        ctrl_r <= hwdata[7:0];
      end
      if (write_collision_flag_set) begin
        ctrl_r.write_collision_flag <= 1'b1;
      end
      if (ovf_set) begin
        ctrl_r.ovf <= 1'b1;
      end
    end
  end

  // only sample phase and edge select are writable
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      {smp_r, cke_r} <= `STAT_RST;
    end else if (dp_wr_r && dp_addr_r == `OFS_STATUS) begin
      smp_r <= hwdata[`STAT_SMP];
      cke_r <= hwdata[`STAT_CKE];
    end
  end

  // received word and buffer_full; overflow keeps the old word
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      buf_r <= 8'h00;
      bf_r  <= 1'b0;
    end else if (done && !ovf_set) begin
      buf_r <= rx_in;
      bf_r  <= 1'b1;
    end else if (buf_rd || !ctrl_r.en) begin
      bf_r  <= 1'b0;
    end
  end

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  // master runs 17 steps so a late sample still fits after edge 16
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= spi_port_pkg::ENG_IDLE;
      h_r     <= 5'h00;
    end else if (!ctrl_r.en || ss_reset) begin
      state_r <= spi_port_pkg::ENG_IDLE;
      h_r     <= 5'h00;
    end else begin
      case (state_r)
        spi_port_pkg::ENG_IDLE: begin
          if (start) begin
            state_r <= spi_port_pkg::ENG_RUN;
            h_r     <= 5'h00;
          end else if (step) begin
            state_r <= spi_port_pkg::ENG_RUN;
            h_r     <= h_nxt;
          end
        end
        spi_port_pkg::ENG_RUN: begin
          if (done) begin
            state_r <= spi_port_pkg::ENG_IDLE;
            h_r     <= 5'h00;
          end else if (step) begin
            h_r     <= h_nxt;
          end
        end
        default: begin
          state_r <= spi_port_pkg::ENG_IDLE;
          h_r     <= 5'h00;
        end
      endcase
    end
  end

  // transmit word: msb out first, loaded only when no word is moving
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_r <= 8'h00;
    end else if (buf_we && !busy) begin
      tx_r <= hwdata[7:0];
    end else if (shft) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // receive shift register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_r <= 8'h00;
    end else if (ss_reset || !ctrl_r.en) begin
      rx_r <= 8'h00;
    end else begin
      rx_r <= rx_in;
    end
  end

  // master clock toggles on steps 1..16 and rests at its idle level
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sck_lvl_r <= 1'b0;
    end else if (!busy || !master) begin
      sck_lvl_r <= ctrl_r.clock_idle_polarity;
    end else if (step && h_nxt <= `LAST_EDGE) begin
      sck_lvl_r <= !sck_lvl_r;
    end
  end

  // slave edge finder on the synchronised clock
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  // pin drivers, one cycle behind the engine
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pins <= '0;
    end else begin
      pins.sck_o  <= master ? sck_lvl_r : ctrl_r.clock_idle_polarity;
      pins.sck_oe <= master;
      pins.sdo_o  <= tx_r[7];
      pins.sdo_oe <= master || (slave && sel_ok);
    end
  end

  // ----------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------
  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_st_r <= 3'h0;
    end else if (dp_wr_r && dp_addr_r == `OFS_IRQ_ST) begin
      irq_st_r <= (irq_st_r & ~hwdata[2:0]) | irq_ev;
    end else begin
      irq_st_r <= irq_st_r | irq_ev;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_r <= 3'h0;
    end else if (dp_wr_r && dp_addr_r == `OFS_IRQ_MASK) begin
      irq_mask_r <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_r & irq_mask_r);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [4:0] tgl_cnt_r;

  // counts master clock toggles within one word
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_cnt_r <= 5'h00;
    end else if (!busy) begin
      tgl_cnt_r <= 5'h00;
    end else if (master && step && h_nxt <= `LAST_EDGE) begin
      tgl_cnt_r <= tgl_cnt_r + 5'd1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_word_length: assert property (done && master |-> tgl_cnt_r == 5'd16)
    else $error("master word did not span sixteen clock edges");
  a_master_drive: assert property (master ##1 master |-> pins.sck_oe)
    else $error("master not driving serial clock");
  a_slave_no_drive: assert property (slave |=> !pins.sck_oe)
    else $error("slave driving serial clock");
  a_disable_quiet: assert property (!ctrl_r.en |=> !busy && !pins.sdo_oe)
    else $error("port active while disabled");
  a_master_no_ss: assert property (master && busy && !done && $stable(ctrl_r) |=> busy)
    else $error("master word aborted");
  a_ss_reset: assert property (ss_reset |=> h_r == 5'h00 && rx_r == 8'h00)
    else $error("select high did not reset serial logic");
  a_out_edge: assert property (master && shft |=> sck_lvl_r == (ctrl_r.clock_idle_polarity ^ cke_r))
    else $error("data changed on wrong clock edge");
  a_bf_set: assert property (done && !(slave && bf_r) |=> bf_r && buf_r == $past(rx_in))
    else $error("completed word not held");
  a_status_rw: assert property (dp_wr_r && dp_addr_r == `OFS_STATUS |=> smp_r == $past(hwdata[7]))
    else $error("sample phase not written");
  a_idle_level: assert property (master && !busy ##1 master && !busy |=> pins.sck_o == $past(ctrl_r.clock_idle_polarity, 2))
    else $error("clock not at idle level");
  a_write_collision_flag_set: assert property (write_collision_flag_set |=> ctrl_r.write_collision_flag && irq_st_r[`IRQ_WRITE_COLLISION_FLAG])
    else $error("collision not flagged");
  a_ovf_keep: assert property (ovf_set |=> ctrl_r.ovf && $stable(buf_r))
    else $error("overflow not flagged or word not dropped");
  a_start_run: assert property (start |=> busy ##[1:600] done)
    else $error("master transfer did not finish");

  c_master_word: cover property (start ##[1:600] done);
  c_slave_word: cover property (slave && done && !bf_r);
  c_overflow: cover property (ovf_set);
  c_collision: cover property (write_collision_flag_set);

endmodule : spi_serial_port

// ### verification/spi_far_end.sv
`timescale 1ns/1ps

// ----------------------------------------
// far-side peripheral facing the port in master mode
// ----------------------------------------
module spi_far_end (
  input  wire logic       sck,
  input  wire logic       sdo,
  output logic            sdi,
  output logic [7:0]      rx
);
  logic [7:0] tx       = 8'h00;
  logic       out_rise = 1'b0;
  logic       late     = 1'b0;
  int         outs     = 100;

  initial sdi = 1'b0;

  // arm one frame; late marks a first edge that is an output edge
  task automatic start(input logic [7:0] t, input logic clock_idle_polarity, input logic cke);
    tx = t;
    out_rise = clock_idle_polarity ^ cke;
    late = cke;
    outs = 0;
    rx = 8'h00;
    sdi = cke ? ~t[7] : t[7];
  endtask : start

  // msb first; outside the frame the line flips so stale data never passes
  always @(sck) begin
    if (sck === out_rise) begin
      outs = outs + 1;
      if (outs - late < 8) sdi = tx[7 - (outs - late)];
      else sdi = ~sdi;
    end else begin
      rx = {rx[6:0], sdo};
    end
  end
endmodule : spi_far_end

// ### verification/tb_top.sv
`timescale 1ns/1ps
`include "spi_port_map.svh"

module tb_top;
  logic                    clk_sys = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    hsel    = 1'b0;
  logic                    hwrite  = 1'b0;
  logic                    ss_n_i  = 1'b1;
  logic                    tmr2_match = 1'b0;
  logic                    tb_sck  = 1'b0;
  logic                    tb_sdi  = 1'b0;
  logic                    slv     = 1'b0;
  logic [31:0]             haddr   = 32'h0;
  logic [31:0]             hwdata  = 32'h0;
  logic [1:0]              htrans  = 2'h0;
  logic [31:0]             hrdata;
  logic [31:0]             q;
  logic                    hreadyout;
  logic                    hresp;
  logic                    irq;
  logic                    far_sdi;
  logic [7:0]              far_rx;
  logic [7:0]              got;
  logic [15:0]             c;
  spi_port_pkg::pins_out_t pins;
  int                      errors = 0;
  int                      cmp_count = 0;
  int                      cyc = 0;
  int                      edges = 0;
  // {mode, ckp, cke, smp, rx check, tx byte}
  logic [15:0] cfg [5] = '{16'h0496, 16'h1b3a, 16'h21c5, 16'h1d71, 16'h37e8};

  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------
  // timer-2 match pulse, hang guard, clock edge count
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    tmr2_match <= (cyc % 10 == 9);
    if (cyc == 60000) begin
      errors++;
      end_of_test();
    end
  end

  always @(pins.sck_o) edges++;

  // pin level: the port drives sck when enabled as master
  spi_serial_port spi_serial_port_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sck_i(pins.sck_oe ? pins.sck_o : tb_sck), .sdi_i(slv ? tb_sdi : far_sdi),
    .ss_n_i(ss_n_i), .tmr2_match(tmr2_match), .pins(pins), .irq(irq)
  );

  spi_far_end spi_far_end_i (.sck(pins.sck_o), .sdo(pins.sdo_o), .sdi(far_sdi), .rx(far_rx));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // single word transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
    chk(hresp, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rd

  // sample off the edge so registered outputs have landed
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic wait_bf();
    for (int n = 0; n < 400; n++) begin
      bus(`OFS_STATUS, 1'b0, 32'h0);
      if (q[0] === 1'b1) break;
    end
    chk(q[0], 32'h1);
  endtask : wait_bf

  // bench as master: sck idles low, data out ahead of the rising edge
  task automatic slv_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge clk_sys);
      tb_sdi <= b[i];
      repeat (4) @(posedge clk_sys);
      tb_sck <= 1'b1;
      got[i] = pins.sdo_o;
      repeat (3) @(posedge clk_sys);
      tb_sck <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
  endtask : slv_bits

  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    idle(1);
    chk(pins, 32'h0);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_IRQ_ST, 32'h0);
    rd(`OFS_IRQ_MASK, 32'h0);
    wr(`OFS_STATUS, 32'hff);
    rd(`OFS_STATUS, 32'hc0);
    rd(8'h40, 32'h0);
    wr(`OFS_STATUS, 32'h0);
    // a buffer write with the port off must not start anything
    wr(`OFS_CTRL, 32'h01);
    wr(`OFS_BUF, 32'ha5);
    idle(300);
    rd(`OFS_STATUS, 32'h0);
    chk(pins.sck_oe, 32'h0);
    // master modes; select pin stays high throughout
    for (int k = 0; k < 5; k++) begin
      c = cfg[k];
      wr(`OFS_CTRL, {27'h0, c[11], c[15:12]});
      wr(`OFS_STATUS, {24'h0, c[9], c[10], 6'h0});
      wr(`OFS_CTRL, {26'h0, 1'b1, c[11], c[15:12]});
      idle(4);
      chk(pins.sck_o, c[11]);
      chk(pins.sck_oe, 32'h1);
      edges = 0;
      spi_far_end_i.start(~c[7:0], c[11], c[10]);
      wr(`OFS_IRQ_MASK, 32'h1);
      wr(`OFS_BUF, {24'h0, c[7:0]});
      wait_bf();
      idle(2);
      chk(irq, 32'h1);
      chk(edges, 32'd16);
      chk(far_rx, c[7:0]);
      bus(`OFS_BUF, 1'b0, 32'h0);
      if (c[8]) chk(q, {24'h0, ~c[7:0]});
      rd(`OFS_STATUS, {24'h0, c[9], c[10], 6'h0});
      wr(`OFS_IRQ_ST, 32'h1);
      idle(2);
      chk(irq, 32'h0);
    end
    // second buffer write lands mid-transfer and is dropped
    wr(`OFS_IRQ_MASK, 32'h0);
    spi_far_end_i.start(8'h0f, 1'b0, 1'b1);
    wr(`OFS_BUF, 32'h3c);
    wr(`OFS_BUF, 32'h99);
    wait_bf();
    chk(far_rx, 32'h3c);
    rd(`OFS_CTRL, 32'ha3);
    rd(`OFS_IRQ_ST, 32'h3);
    idle(2);
    chk(irq, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h2);
    idle(2);
    chk(irq, 32'h1);
    wr(`OFS_IRQ_ST, 32'h3);
    idle(2);
    chk(irq, 32'h0);
    wr(`OFS_CTRL, 32'h23);
    rd(`OFS_CTRL, 32'h23);
    bus(`OFS_BUF, 1'b0, 32'h0);
    // slave without select: unread word then a second word
    wr(`OFS_CTRL, 32'h05);
    wr(`OFS_STATUS, 32'h0);
    wr(`OFS_CTRL, 32'h25);
    @(posedge clk_sys);
    slv <= 1'b1;
    wr(`OFS_BUF, 32'h5a);
    slv_bits(8'hc3, 8);
    chk(got, 32'h5a);
    chk(pins.sck_oe, 32'h0);
    rd(`OFS_STATUS, 32'h1);
    slv_bits(8'h81, 8);
    rd(`OFS_CTRL, 32'h65);
    rd(`OFS_IRQ_ST, 32'h5);
    rd(`OFS_BUF, 32'hc3);
    // slave with select: a deselect drops a word after 3 of its 8 bits
    wr(`OFS_CTRL, 32'h04);
    wr(`OFS_CTRL, 32'h24);
    idle(4);
    chk(pins.sdo_oe, 32'h0);
    @(posedge clk_sys);
    ss_n_i <= 1'b0;
    slv_bits(8'hff, 3);
    @(posedge clk_sys);
    ss_n_i <= 1'b1;
    idle(6);
    @(posedge clk_sys);
    ss_n_i <= 1'b0;
    slv_bits(8'h6e, 8);
    rd(`OFS_BUF, 32'h6e);
    end_of_test();
  end
endmodule : tb_top
